//--- design/pbd_pkg.sv
/*
  Constants for the PROM board bus decoder: timing, field positions,
  register offsets, reset values and state and size encodings.
  Assumes a 40 MHz system clock and a 15-bit word address bus.
*/
package pbd_pkg;
  // Bus and array shape
  localparam int PBD_ADDR_W = 15;
  localparam int PBD_DATA_W = 16;
  localparam int PBD_BANKS = 8;
  localparam int PBD_MEM_WORDS = 4096;
  localparam int PBD_SEL_BITS = 4;
  localparam int PBD_PROG_AW = 12;
  // Timing in nanoseconds and derived clock counts
  localparam int PBD_CLK_NS = 25;
  localparam int PBD_CYCLE_NS = 960;
  localparam int PBD_ACCESS_NS = 100;
  localparam int PBD_CYCLE_CLKS = PBD_CYCLE_NS / PBD_CLK_NS;
  localparam int PBD_ACCESS_CLKS =
    (PBD_ACCESS_NS + PBD_CLK_NS - 1) / PBD_CLK_NS;
  localparam int PBD_CYC_W = 6;
  localparam logic [5:0] PBD_ACCESS_CYC = 6'(PBD_ACCESS_CLKS);
  localparam logic [5:0] PBD_LAST_CYC = 6'(PBD_CYCLE_CLKS - 1);
  // Register byte offsets
  localparam logic [11:0] PBD_CFG_OFF = 12'h000;
  localparam logic [11:0] PBD_STAT_OFF = 12'h004;
  localparam logic [11:0] PBD_CNT_OFF = 12'h008;
  // Configuration fields and reset value
  localparam int PBD_CFG_ONE_LSB = 0;
  localparam int PBD_CFG_ZERO_LSB = 4;
  localparam int PBD_CFG_SIZE_LSB = 8;
  localparam logic [31:0] PBD_CFG_RST = 32'h0000_0000;
  // Status fields
  localparam int PBD_STAT_BANK_LSB = 15;
  localparam int PBD_STAT_BUSY_BIT = 18;
  localparam int PBD_STAT_VALID_BIT = 19;
  // Board capacity codes
  typedef enum logic [1:0] {
    PBD_SZ_512 = 2'b00,
    PBD_SZ_1K = 2'b01,
    PBD_SZ_2K = 2'b10,
    PBD_SZ_4K = 2'b11
  } pbd_size_e;
  // Read cycle states
  typedef enum logic [1:0] {
    PBD_ST_IDLE = 2'b00,
    PBD_ST_POWER = 2'b01,
    PBD_ST_DRIVE = 2'b10
  } pbd_state_e;
endpackage : pbd_pkg

//--- design/pbd_prom_board.sv
/*
  PROM board: decodes read cycles on the word memory bus, powers one
  bank, drives the addressed word with the RAM inhibit line, and holds
  the jumper configuration in APB registers.
  Assumes memory bus and programmer pins are asynchronous to clock and
  held stable for the whole bus cycle; APB runs on clock.
*/
// The placing of the registers and the APB slave port were chosen for this implementation.
// Operation
// - Start address on any 2K-word boundary
// - Inhibit line lets ROM beat overlapping RAM
// - Latch address only when inside configured range
// - High address bits power exactly one bank
// - Low eight bits go to every bank
// - Banks not being read stay unpowered
// - In-range read drives word and inhibit
// - Two to eight banks, 256 or 512 words
// - Capacity 512, 1024, 2048 or 4096 words
// - Read cycle finishes within 960 ns
// - Start bits 1-4 each set by pair
// - Bit 4 selection ignored on 4K board
// - Bus writes never alter stored words
// - Bank selects and data taps reach connector
`timescale 1ns/1ps
module pbd_prom_board
  import pbd_pkg::*;
#(
  parameter int ADDR_W = PBD_ADDR_W,
  parameter int DATA_W = PBD_DATA_W,
  parameter int BANKS = PBD_BANKS,
  parameter int MEM_WORDS = PBD_MEM_WORDS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory bus
  input wire logic mem_start,
  input wire logic mem_read,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  output logic ram_inhibit,
  // PROM banks
  output logic [BANKS-1:0] bank_pwr,
  output logic [8:0] prom_addr,
  // Auxiliary connector
  output logic [DATA_W-1:0] aux_data_tap,
  input wire logic prog_we,
  input wire logic [PBD_PROG_AW-1:0] prog_addr,
  input wire logic [DATA_W-1:0] prog_data
);
  localparam int PIN_W = 3 + ADDR_W + PBD_PROG_AW + DATA_W;
  localparam int CYC_MAX = PBD_CYCLE_CLKS;

  // Capacity in words for a size code
  function automatic logic [12:0] size_words(input pbd_size_e sz);
    return 13'h200 << sz;
  endfunction : size_words

  // Bank index from board offset
  function automatic logic [2:0] bank_of(input logic [11:0] off,
                                         input logic big);
    return big ? off[11:9] : off[10:8];
  endfunction : bank_of

  logic [PIN_W-1:0] pin_s1, pin_s2;
  logic start_prev, prog_prev;
  logic s_start, s_read, s_prog_we;
  logic [ADDR_W-1:0] s_addr, lat_addr;
  logic [PBD_PROG_AW-1:0] s_prog_addr;
  logic [DATA_W-1:0] s_prog_data;
  logic start_edge, prog_fire;
  logic [PBD_SEL_BITS-1:0] cfg_one, cfg_zero;
  pbd_size_e cfg_size;
  logic is4k, start_ok, start_hit, in_range, prog_allow;
  logic [11:0] off, lat_off;
  pbd_state_e state;
  logic [PBD_CYC_W-1:0] cyc;
  logic lat_4k, reg_hit;
  logic [DATA_W-1:0] rom [MEM_WORDS];
  logic [15:0] reads_served, writes_ignored;
  logic [31:0] rd_mux;

  // Two-flop synchroniser for every pin input
  always_ff @(posedge clock) begin
    pin_s1 <= {mem_start, mem_read, mem_addr, prog_we, prog_addr,
               prog_data};
    pin_s2 <= pin_s1;
  end

  assign {s_start, s_read, s_addr, s_prog_we, s_prog_addr, s_prog_data} =
    pin_s2;

  // Edge memory for start and program strobes
  always_ff @(posedge clock) begin
    if (srst) begin
      start_prev <= 1'b0;
      prog_prev <= 1'b0;
    end else begin
      start_prev <= s_start;
      prog_prev <= s_prog_we;
    end
  end

  assign start_edge = s_start && !start_prev;
  assign prog_fire = s_prog_we && !prog_prev;
  assign is4k = (cfg_size == PBD_SZ_4K);

  // Start address match; each bit needs exactly one of its pair
  always_comb begin
    start_ok = 1'b1;
    start_hit = 1'b1;
    for (int i = 0; i < PBD_SEL_BITS; i++) begin
      if (!(i == PBD_SEL_BITS - 1 && is4k)) begin
        if (cfg_one[i] == cfg_zero[i]) begin
          start_ok = 1'b0;
        end
        if (s_addr[ADDR_W-1-i] != cfg_one[i]) begin
          start_hit = 1'b0;
        end
      end
    end
  end

  // Offset within the board and range check
  assign off = is4k ? s_addr[11:0] : {1'b0, s_addr[10:0]};
  assign in_range = start_ok && start_hit &&
    ({1'b0, off} < size_words(cfg_size));
  assign prog_allow = (cfg_one == '0) && (cfg_zero == '0) &&
    (state == PBD_ST_IDLE);

  // Read cycle sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= PBD_ST_IDLE;
      cyc <= '0;
    end else begin
      case (state)
        PBD_ST_IDLE: begin
          cyc <= '0;
          if (start_edge && s_read && in_range) begin
            state <= PBD_ST_POWER;
            cyc <= 6'h01;
          end
        end
        PBD_ST_POWER: begin
          cyc <= cyc + 6'h01;
          if (cyc == PBD_ACCESS_CYC) begin
            state <= PBD_ST_DRIVE;
          end
        end
        PBD_ST_DRIVE: begin
          cyc <= cyc + 6'h01;
          if (cyc == PBD_LAST_CYC) begin
            state <= PBD_ST_IDLE;
          end
        end
        default: begin
          state <= PBD_ST_IDLE;
        end
      endcase
    end
  end

  // Address latch, bank power and common word address
  always_ff @(posedge clock) begin
    if (srst) begin
      lat_addr <= '0;
      lat_off <= '0;
      lat_4k <= 1'b0;
      bank_pwr <= '0;
      prom_addr <= '0;
    end else if (state == PBD_ST_IDLE && start_edge && s_read &&
                 in_range) begin
      lat_addr <= s_addr;
      lat_off <= off;
      lat_4k <= is4k;
      bank_pwr <= BANKS'(1) << bank_of(off, is4k);
      prom_addr <= {is4k & off[8], off[7:0]};
    end else if (state == PBD_ST_DRIVE && cyc == PBD_LAST_CYC) begin
      bank_pwr <= '0;
    end
  end

  // Word and inhibit drive onto the bus and connector taps
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_data_out <= '0;
      mem_data_oe <= 1'b0;
      ram_inhibit <= 1'b0;
      aux_data_tap <= '0;
    end else if (state == PBD_ST_POWER && cyc == PBD_ACCESS_CYC) begin
      mem_data_out <= rom[lat_off];
      aux_data_tap <= rom[lat_off];
      mem_data_oe <= 1'b1;
      ram_inhibit <= 1'b1;
    end else if (state != PBD_ST_DRIVE || cyc == PBD_LAST_CYC) begin
      mem_data_oe <= 1'b0;
      ram_inhibit <= 1'b0;
    end
  end

  // Array loads only from the programmer, never from bus writes
  always_ff @(posedge clock) begin
    if (prog_fire && prog_allow) begin
      rom[s_prog_addr] <= s_prog_data;
    end
  end

  // Activity counters
  always_ff @(posedge clock) begin
    if (srst) begin
      reads_served <= '0;
      writes_ignored <= '0;
    end else if (state == PBD_ST_IDLE && start_edge) begin
      if (s_read && in_range) begin
        reads_served <= reads_served + 16'h0001;
      end else if (!s_read && in_range) begin
        writes_ignored <= writes_ignored + 16'h0001;
      end
    end
  end

  // Configuration register
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_one <= PBD_CFG_RST[PBD_CFG_ONE_LSB +: PBD_SEL_BITS];
      cfg_zero <= PBD_CFG_RST[PBD_CFG_ZERO_LSB +: PBD_SEL_BITS];
      cfg_size <= pbd_size_e'(PBD_CFG_RST[PBD_CFG_SIZE_LSB +: 2]);
    end else if (psel && penable && pready && pwrite &&
                 paddr == PBD_CFG_OFF) begin
      cfg_one <= pwdata[PBD_CFG_ONE_LSB +: PBD_SEL_BITS];
      cfg_zero <= pwdata[PBD_CFG_ZERO_LSB +: PBD_SEL_BITS];
      cfg_size <= pbd_size_e'(pwdata[PBD_CFG_SIZE_LSB +: 2]);
    end
  end

  // Register read decode
  always_comb begin
    reg_hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      PBD_CFG_OFF: begin
        rd_mux[PBD_CFG_ONE_LSB +: PBD_SEL_BITS] = cfg_one;
        rd_mux[PBD_CFG_ZERO_LSB +: PBD_SEL_BITS] = cfg_zero;
        rd_mux[PBD_CFG_SIZE_LSB +: 2] = cfg_size;
      end
      PBD_STAT_OFF: begin
        rd_mux[ADDR_W-1:0] = lat_addr;
        rd_mux[PBD_STAT_BANK_LSB +: 3] = bank_of(lat_off, lat_4k);
        rd_mux[PBD_STAT_BUSY_BIT] = (state != PBD_ST_IDLE);
        rd_mux[PBD_STAT_VALID_BIT] = start_ok;
      end
      PBD_CNT_OFF: begin
        rd_mux = {writes_ignored, reads_served};
      end
      default: begin
        reg_hit = 1'b0;
      end
    endcase
  end

  // APB answer: ready in the first access cycle, error on unmapped
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !reg_hit;
        prdata <= pwrite ? '0 : rd_mux;
      end
    end
  end

  // Checks
  bank_onehot_a: assert property (
    @(posedge clock) disable iff (srst) $onehot0(bank_pwr))
    else $error("more than one bank powered");
  idle_unpowered_a: assert property (
    @(posedge clock) disable iff (srst)
    state == PBD_ST_IDLE |-> bank_pwr == '0)
    else $error("bank powered while idle");
  bank_select_a: assert property (
    @(posedge clock) disable iff (srst)
    state != PBD_ST_IDLE |->
      bank_pwr == BANKS'(1) << bank_of(lat_off, lat_4k))
    else $error("wrong bank powered");
  word_route_a: assert property (
    @(posedge clock) disable iff (srst)
    state != PBD_ST_IDLE |-> prom_addr[7:0] == lat_addr[7:0])
    else $error("word address not from latch");
  inhibit_pair_a: assert property (
    @(posedge clock) disable iff (srst)
    mem_data_oe |-> ram_inhibit && state == PBD_ST_DRIVE)
    else $error("data driven without inhibit");
  cycle_time_a: assert property (
    @(posedge clock) disable iff (srst)
    (state == PBD_ST_IDLE ##1 state != PBD_ST_IDLE) |->
      ##[1:CYC_MAX] state == PBD_ST_IDLE)
    else $error("read cycle overran");
  out_range_a: assert property (
    @(posedge clock) disable iff (srst)
    (state == PBD_ST_IDLE && start_edge && !(s_read && in_range)) |=>
      state == PBD_ST_IDLE && !mem_data_oe && !ram_inhibit)
    else $error("out-of-range cycle answered");
  read_drive_a: assert property (
    @(posedge clock) disable iff (srst)
    (state == PBD_ST_IDLE && start_edge && s_read && in_range) |->
      ##5 mem_data_oe && ram_inhibit && mem_data_out == aux_data_tap)
    else $error("in-range read not driven");
  start_decode_a: assert property (
    @(posedge clock) disable iff (srst)
    (state == PBD_ST_IDLE && start_edge && s_read && in_range) |=>
      lat_addr[ADDR_W-1 -: 3] == {cfg_one[0], cfg_one[1], cfg_one[2]})
    else $error("latched address outside start block");
  prog_guard_a: assert property (
    @(posedge clock) disable iff (srst)
    (prog_fire && (cfg_one != '0 || cfg_zero != '0)) |=>
      rom[$past(s_prog_addr)] == $past(rom[s_prog_addr]))
    else $error("programming with selections present");
endmodule : pbd_prom_board

//--- bench/pbd_cpu_model.sv
/* CPU side of the word memory bus: runs one bus cycle per call.
   Assumes the board clock; address lines are scrambled between cycles. */
`timescale 1ns/1ps
module pbd_cpu_model (
  // Clock
  input wire logic clock,
  // Board answer
  input wire logic mem_data_oe,
  // Bus request
  output logic mem_start,
  output logic mem_read,
  output logic [14:0] mem_addr
);
  int lat = 0;
  // Quiet bus at time zero
  initial begin
    mem_start = 1'b0;
    mem_read = 1'b0;
    mem_addr = 15'h0;
  end
  // Hold one request for a full cycle and time the answer
  task automatic cycle(input logic [14:0] a, input logic rd);
    logic seen;
    @(posedge clock);
    mem_addr <= a;
    mem_read <= rd;
    @(posedge clock);
    mem_start <= 1'b1;
    lat = 0;
    seen = 1'b0;
    repeat (44) begin
      @(posedge clock);
      if (mem_data_oe === 1'b1) seen = 1'b1;
      else if (!seen) lat++;
    end
    mem_start <= 1'b0;
    mem_addr <= ~a; // Released lines do not keep the last value
    mem_read <= ~rd;
    repeat (4) @(posedge clock);
  endtask : cycle
endmodule : pbd_cpu_model

//--- bench/testbench.sv
/* Bench for the PROM board: APB setup, burning, bus reads.
   Assumes pbd_pkg and the CPU bus model are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import pbd_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic prog_we = 1'b0;
  logic [11:0] prog_addr = 12'h0;
  logic [15:0] prog_data = 16'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mem_start, mem_read, mem_data_oe, ram_inhibit;
  logic [14:0] mem_addr;
  logic [15:0] mem_data_out, aux_data_tap;
  logic [7:0] bank_pwr;
  logic [8:0] prom_addr;
  logic [15:0] img [0:4095];
  logic [32:0] exp_q [$];
  logic oe_q = 1'b0;
  int failures = 0;
  int n_compared = 0;
  // Config, read flag and address of each bus cycle
  logic [25:0] tab [16] = '{
    26'h2a5d000, 26'h2a5d1ff, 26'h2a5d200, 26'h2a5d7ff,
    26'h2a5d800, 26'h2a59000, 26'h2a55000, 26'h2a5d000,
    26'h3add800, 26'h3addfff, 26'h3add1ff, 26'h3adcfff,
    26'h0a5d000, 26'h0a5d1ff, 26'h0a5d200, 26'h2a4d000};

  always #12.5 clock = ~clock;

  pbd_prom_board pbd_prom_board_i (.clock(clock), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_start(mem_start), .mem_read(mem_read),
    .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .ram_inhibit(ram_inhibit),
    .bank_pwr(bank_pwr), .prom_addr(prom_addr),
    .aux_data_tap(aux_data_tap), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data));

  pbd_cpu_model cpu_i (.clock(clock), .mem_data_oe(mem_data_oe),
    .mem_start(mem_start), .mem_read(mem_read), .mem_addr(mem_addr));

  // Board selected by this config and address
  function automatic logic hit(input logic [9:0] c,
                               input logic [14:0] a);
    for (int i = 0; i < 4; i++) begin
      if (i == 3 && c[9:8] == 2'b11) continue;
      if (c[i] == c[4+i] || a[14-i] != c[i]) return 1'b0;
    end
    if (c[9:8] != 2'b11 && (a[10:0] >> (9 + c[9:8])) != 0) return 1'b0;
    return 1'b1;
  endfunction : hit

  // Expected word, bank power and bank address
  function automatic logic [32:0] note(input logic [9:0] c,
                                       input logic [14:0] a);
    logic [11:0] o;
    o = (c[9:8] == 2'b11) ? a[11:0] : {1'b0, a[10:0]};
    if (c[9:8] == 2'b11) return {img[o], 8'h1 << o[11:9], o[8:0]};
    return {img[o], 8'h1 << o[10:8], 1'b0, o[7:0]};
  endfunction : note

  // One APB transfer, waiting for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Wait as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Burn one word through the auxiliary connector
  task automatic prog(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    prog_addr <= a;
    prog_data <= d;
    @(posedge clock);
    prog_we <= 1'b1;
    repeat (3) @(posedge clock);
    prog_we <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : prog

  task automatic close_out();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Compare each bus answer with the oldest note
  always @(posedge clock) begin
    logic [32:0] e;
    if (mem_data_oe === 1'b1 && oe_q !== 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
      `CHK("data", e[32:17], mem_data_out)
      `CHK("inhibit", 1'b1, ram_inhibit)
      `CHK("bank_pwr", e[16:9], bank_pwr)
      `CHK("prom_addr", e[8:0], prom_addr)
      `CHK("aux_tap", e[32:17], aux_data_tap)
    end
    oe_q <= mem_data_oe;
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    logic [9:0] c;
    logic [14:0] a;
    int nr;
    int nw;
    void'($urandom(32'hc496));
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    apb(1'b0, PBD_CFG_OFF, 32'h0, q, e);
    `CHK("cfg_rst", PBD_CFG_RST, q)
    apb(1'b0, 12'h00c, 32'h0, q, e);
    `CHK("pslverr", 1'b1, e)
    // Burn with no start selections in place
    foreach (tab[i]) begin
      img[tab[i][11:0]] = 16'($urandom);
      prog(tab[i][11:0], img[tab[i][11:0]]);
    end
    // Top word overlaps another ROM, so this copy burns as all ones
    img[12'hfff] = 16'hffff;
    prog(12'hfff, 16'hffff);
    c = 10'h0;
    foreach (tab[i]) begin
      a = tab[i][14:0];
      if (tab[i][25:16] != c) begin
        c = tab[i][25:16];
        apb(1'b1, PBD_CFG_OFF, {22'h0, c}, q, e);
        apb(1'b0, PBD_CFG_OFF, 32'h0, q, e);
        `CHK("cfg", {22'h0, c}, q)
        // Selections now in place: this burn must be refused
        prog(a[11:0], ~img[a[11:0]]);
      end
      if (tab[i][15] && hit(c, a)) exp_q.push_back(note(c, a));
      if (hit(c, a) && tab[i][15]) nr++;
      if (hit(c, a) && !tab[i][15]) nw++;
      cpu_i.cycle(a, tab[i][15]);
      `CHK("backlog", 0, exp_q.size())
      `CHK("idle_pwr", 8'h0, bank_pwr)
      if (tab[i][15] && hit(c, a))
        `CHK("latency", 1'b1, cpu_i.lat <= 38)
      else
        `CHK("quiet", 44, cpu_i.lat)
    end
    // Read-back of the activity counters
    apb(1'b0, PBD_CNT_OFF, 32'h0, q, e);
    `CHK("count", {nw[15:0], nr[15:0]}, q)
    close_out();
  end

  // Watchdog against a hung bus
  initial begin
    #2000000;
    failures++;
    close_out();
  end
endmodule : testbench
